// File: dv/cfl_engine_model.sv
// Protocol engine model: asks the layout block for buffer addresses on the lookup port.
// Assumes the block answers one cycle after a request and drops the answer while busy.
`timescale 1ns/1ps
`default_nettype none
module cfl_engine_model (
  input  wire logic                 i_clk_sys,  // System clock
  output var  cfl_pkg::cfl_lk_req_t o_lk,       // Lookup request
  input  wire logic [31:0]          i_lk_addr,  // Answered address
  input  wire logic                 i_lk_valid  // Answer valid
);
  initial o_lk = '0;

  // One request, retried until the block answers with a settled layout
  task automatic lookup(input logic [4:0] f, input logic [4:0] b, output logic [31:0] a);
    logic got;
    got = 1'b0;
    while (!got)
    begin
      @(posedge i_clk_sys);
      o_lk <= '{1'b1, f, b};
      @(posedge i_clk_sys);
      o_lk <= '{1'b0, ~f, ~b};  // Idle fields never repeat the last request
      @(posedge i_clk_sys);
      got = (i_lk_valid === 1'b1);
      a = i_lk_addr;
    end
  endtask
endmodule
`default_nettype wire

// File: dv/cfl_fifo_layout_tb.sv
// Testbench for the FIFO layout block: Avalon register tasks and layout scenarios.
// Assumes the engine model on the lookup port and a 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module cfl_fifo_layout_tb;
  logic                 clk;
  logic                 rst_n;
  logic [8:0]           adr;
  logic                 rd;
  logic                 wr;
  logic [31:0]          wdat;
  logic [31:0]          rdat;
  logic                 wreq;
  cfl_pkg::cfl_lk_req_t lk;
  logic [31:0]          lk_addr;
  logic                 lk_valid;
  logic                 busy;
  logic [31:0]          base;
  logic [2:0]           op;
  logic [31:0]          v;
  int                   err_count;
  int                   cmp_count;

  cfl_fifo_layout dut (.i_clk_sys(clk), .i_arst_n(rst_n), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(4'hf), .i_avs_writedata(wdat),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_lk(lk), .o_lk_addr(lk_addr),
    .o_lk_valid(lk_valid), .o_base(base), .o_op_code(op), .o_layout_busy(busy));
  cfl_engine_model eng (.i_clk_sys(clk), .o_lk(lk), .i_lk_addr(lk_addr),
    .i_lk_valid(lk_valid));

  // Clock generation
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Avalon write, held until waitrequest is sampled low
  task automatic av_wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    wr <= 1'b0;
  endtask

  // Avalon read, data taken at the accepting edge
  task automatic av_rd(input logic [8:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    adr <= a;
    do @(posedge clk); while (wreq !== 1'b0);
    d = rdat;
    rd <= 1'b0;
  endtask

  // Word comparison
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // Buffer address through the lookup registers
  task automatic lk_chk(input logic [4:0] f, input logic [4:0] b, input logic [31:0] e);
    av_wr(cfl_pkg::OFS_LKSEL, {19'h0, b, 3'h0, f});
    av_rd(cfl_pkg::OFS_LKADDR, v);
    chk("lookup address", e, v);
  endtask

  // Request a mode and poll the current code
  task automatic set_mode(input logic [2:0] m);
    av_wr(cfl_pkg::OFS_CTRL, {5'h0, m, 24'h0});
    for (int i = 0; i < 40; i++)
    begin
      av_rd(cfl_pkg::OFS_CTRL, v);
      if (v[23:21] === m)
        break;
    end
    chk("current op code", {29'h0, m}, {29'h0, v[23:21]});
  endtask

  // Verdict and end of run
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    #100000;
    err_count++;
    print_verdict();
  end

  // Test sequence
  initial
  begin
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 9'h000;
    wdat = 32'h0;
    err_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    av_rd(cfl_pkg::OFS_CTRL, v);
    chk("reset op code", 32'h4, {29'h0, v[23:21]});
    av_rd(cfl_pkg::OFS_TOTAL, v);
    chk("reset total", 32'h200, v);
    lk_chk(5'h05, 5'h00, 32'h50);
    $display("test reset layout done");
    av_wr(cfl_pkg::OFS_BASE, 32'h1000);
    repeat (2) @(posedge clk);
    chk("layout busy", 32'h1, {31'h0, busy});
    av_wr(cfl_pkg::OFS_FIFO0, 32'h00030080);
    av_wr(cfl_pkg::OFS_FIFO0 + 9'h004, 32'h00011000);
    av_wr(cfl_pkg::OFS_FIFO0 + 9'h00c, 32'h00030000);
    lk_chk(5'h00, 5'h03, 32'h1030);
    lk_chk(5'h01, 5'h01, 32'h1048);
    lk_chk(5'h02, 5'h00, 32'h1050);
    lk_chk(5'h03, 5'h03, 32'h1090);
    av_rd(cfl_pkg::OFS_TOTAL, v);
    chk("total", 32'h260, v);
    chk("layout idle", 32'h0, {31'h0, busy});
    eng.lookup(5'h03, 5'h02, v);
    chk("engine address", 32'h1080, v);
    eng.lookup(5'h01, 5'h01, v);
    chk("engine data address", 32'h1048, v);
    chk("base output", 32'h1000, base);
    $display("test mixed layout done");
    set_mode(cfl_pkg::OP_NORMAL);
    chk("op code output", 32'h0, {29'h0, op});
    av_wr(cfl_pkg::OFS_BASE, 32'h2000);
    av_rd(cfl_pkg::OFS_BASE, v);
    chk("locked base", 32'h1000, v);
    av_wr(cfl_pkg::OFS_FIFO0, 32'h001f1000);
    av_rd(cfl_pkg::OFS_FIFO0, v);
    chk("locked fifo control", 32'h00030000, v);
    av_rd(9'h020, v);
    chk("unmapped read", 32'h0, v);
    $display("test normal mode lock done");
    set_mode(cfl_pkg::OP_CONFIG);
    av_wr(cfl_pkg::OFS_BASE, 32'h2000);
    av_wr(cfl_pkg::OFS_FIFO0, 32'h00010080);
    av_wr(cfl_pkg::OFS_FIFO0 + 9'h004, 32'h00010080);
    av_wr(cfl_pkg::OFS_FIFO0 + 9'h008, 32'h00020000);
    av_wr(cfl_pkg::OFS_FIFO0 + 9'h00c, 32'h00020000);
    eng.lookup(5'h02, 5'h00, v);
    chk("engine address", 32'h2040, v);
    lk_chk(5'h01, 5'h00, 32'h2020);
    lk_chk(5'h03, 5'h02, 32'h2090);
    av_rd(cfl_pkg::OFS_TOTAL, v);
    chk("total", 32'h260, v);
    $display("test second layout done");
    print_verdict();
  end
endmodule
`default_nettype wire

// File: rtl/cfl_fifo_layout.sv
// Message FIFO layout block: mode control, base and FIFO registers, address lookup.
// Assumes an Avalon-MM master with waitrequest and a protocol engine on the same clock.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// (RULE1) Transmit buffer takes four words, sixteen bytes
// (RULE2) Full receive buffer takes four words
// (RULE3) Payload-only receive buffer takes two words
// (RULE4) Buffer count field in bits 20:16
// (RULE5) Every FIFO holds at least one buffer
// (RULE6) Unconfigured FIFO still reserves four words
// (RULE7) Start sums footprints of all lower FIFOs
// (RULE8) Base register is origin of all addresses
// (RULE9) Direction bit set means transmit FIFO
// (RULE10) Software configures only in configuration mode; code accepts direction bit writes in every mode
// (RULE11) Count field holds buffer count minus one
// (RULE12) Payload-only receive buffers spaced two words
// (RULE13) Software should fill FIFOs from zero upward
// (RULE14) FIFOs and buffers packed without gaps
// (RULE15) Base, size, payload flag locked outside configuration
// (RULE16) Buffer address is start plus k sizes
module cfl_fifo_layout (
  input  wire logic                 i_clk_sys,          // System clock, 200 MHz
  input  wire logic                 i_arst_n,           // Async reset, active low
  input  wire logic [8:0]           i_avs_address,      // Avalon byte address
  input  wire logic                 i_avs_read,         // Avalon read
  input  wire logic                 i_avs_write,        // Avalon write
  input  wire logic [3:0]           i_avs_byteenable,   // Avalon byte enables
  input  wire logic [31:0]          i_avs_writedata,    // Avalon write data
  output var  logic [31:0]          o_avs_readdata,     // Avalon read data
  output var  logic                 o_avs_waitrequest,  // Avalon wait request
  input  wire cfl_pkg::cfl_lk_req_t i_lk,               // Engine lookup request
  output var  logic [31:0]          o_lk_addr,          // Looked-up buffer address
  output var  logic                 o_lk_valid,         // Lookup answer valid
  output var  logic [31:0]          o_base,             // Origin of the layout
  output var  logic [2:0]           o_op_code,          // Current op code
  output var  logic                 o_layout_busy       // Layout being recomputed
);

  // Register state
  logic [2:0]                                  req_op;
  logic [31:0]                                 base;
  cfl_pkg::cfl_fifo_cfg_t [cfl_pkg::NUM_FIFO-1:0] fcfg;
  logic [4:0]                                  lk_fifo;
  logic [4:0]                                  lk_buf;
  logic                                        kick;

  // Submodule outputs
  logic [2:0]                                  cur_op;
  logic                                        in_config;
  logic                                        walk_busy;
  logic [cfl_pkg::NUM_FIFO-1:0][31:0]          start_addr;
  logic [31:0]                                 total;

  // Decode
  logic        hit_ctrl;
  logic        hit_base;
  logic        hit_lksel;
  logic        hit_lkaddr;
  logic        hit_total;
  logic        hit_fifo;
  logic [4:0]  fifo_sel;
  logic        lay_stall;
  logic        acc_ok;
  logic        wr_fire;
  logic [31:0] next_rdata;
  logic [31:0] cur_word;
  logic [31:0] wr_word;

  cfl_op_mode u_op_mode (
    .i_clk_sys   (i_clk_sys),
    .i_arst_n    (i_arst_n),
    .i_req_op    (req_op),
    .o_cur_op    (cur_op),
    .o_in_config (in_config)
  );

  cfl_layout_walk u_walk (
    .i_clk_sys    (i_clk_sys),
    .i_arst_n     (i_arst_n),
    .i_start      (kick),
    .i_base       (base),
    .i_cfg        (fcfg),
    .o_busy       (walk_busy),
    .o_start_addr (start_addr),
    .o_total      (total)
  );

  // Address decode
  assign hit_ctrl   = (i_avs_address == cfl_pkg::OFS_CTRL);
  assign hit_base   = (i_avs_address == cfl_pkg::OFS_BASE);
  assign hit_lksel  = (i_avs_address == cfl_pkg::OFS_LKSEL);
  assign hit_lkaddr = (i_avs_address == cfl_pkg::OFS_LKADDR);
  assign hit_total  = (i_avs_address == cfl_pkg::OFS_TOTAL);
  assign hit_fifo   = (i_avs_address >= cfl_pkg::OFS_FIFO0) &&
                      (i_avs_address <= cfl_pkg::OFS_FIFO_LAST) &&
                      (i_avs_address[1:0] == 2'h0);
  assign fifo_sel   = i_avs_address[6:2];

  // Layout reads wait until the walk has settled
  assign lay_stall  = walk_busy || kick;
  assign acc_ok     = (i_avs_read || i_avs_write) && o_avs_waitrequest &&
                      !(i_avs_read && (hit_lkaddr || hit_total) && lay_stall);
  assign wr_fire    = i_avs_write && !o_avs_waitrequest;

  // Present contents of the addressed word
  always_comb
  begin
    cur_word = 32'h0;
    if (hit_ctrl)
    begin
      cur_word[cfl_pkg::REQ_MSB:cfl_pkg::REQ_LSB] = req_op;
      cur_word[cfl_pkg::CUR_MSB:cfl_pkg::CUR_LSB] = cur_op;
      cur_word[cfl_pkg::BUSY_BIT]                 = lay_stall;
    end
    else if (hit_base)
      cur_word = base;
    else if (hit_lksel)
    begin
      cur_word[cfl_pkg::LK_FIFO_MSB:cfl_pkg::LK_FIFO_LSB] = lk_fifo;
      cur_word[cfl_pkg::LK_BUF_MSB:cfl_pkg::LK_BUF_LSB]   = lk_buf;
    end
    else if (hit_fifo)
    begin
      cur_word[cfl_pkg::SIZE_MSB:cfl_pkg::SIZE_LSB] = fcfg[fifo_sel].size;
      cur_word[cfl_pkg::PAYLOAD_ONLY_FLAG_BIT]                  = fcfg[fifo_sel].payload_only_flag;
      cur_word[cfl_pkg::DIR_BIT]                    = fcfg[fifo_sel].dir;
    end
  end

  // Read mux; unmapped words read as zero
  always_comb
  begin
    next_rdata = cur_word;
    if (hit_lkaddr)
      next_rdata = cfl_pkg::addr_of(start_addr[lk_fifo], fcfg[lk_fifo], lk_buf); // [RULE16]
    else if (hit_total)
      next_rdata = total;
  end

  assign wr_word = cfl_pkg::be_merge(cur_word, i_avs_writedata, i_avs_byteenable);

  // Wait request: one low cycle per accepted access
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_avs_waitrequest <= 1'b1;
    else
      o_avs_waitrequest <= !acc_ok;
  end

  // Read data captured with the answer
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_avs_readdata <= 32'h0;
    else if (acc_ok && i_avs_read)
      o_avs_readdata <= next_rdata;
  end

  // Requested mode, reset to configuration
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      req_op <= cfl_pkg::OP_CONFIG;
    else if (wr_fire && hit_ctrl)
      req_op <= wr_word[cfl_pkg::REQ_MSB:cfl_pkg::REQ_LSB];
  end

  // Base address, writable only in configuration mode
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      base <= cfl_pkg::BASE_RESET;
    else if (wr_fire && hit_base && in_config)          // [RULE15]
      base <= wr_word;                                  // [RULE8]
  end

  // FIFO settings; size and payload flag locked outside configuration
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      fcfg <= '0;                                       // [RULE5] [RULE6]
    else if (wr_fire && hit_fifo)
    begin
      fcfg[fifo_sel].dir <= wr_word[cfl_pkg::DIR_BIT];  // [RULE9]
      if (in_config)                                    // [RULE15]
      begin
        fcfg[fifo_sel].size  <= wr_word[cfl_pkg::SIZE_MSB:cfl_pkg::SIZE_LSB]; // [RULE4]
        fcfg[fifo_sel].payload_only_flag <= wr_word[cfl_pkg::PAYLOAD_ONLY_FLAG_BIT]; // [RULE12]
      end
    end
  end

  // Lookup selection for software reads
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      lk_fifo <= 5'h0;
      lk_buf  <= 5'h0;
    end
    else if (wr_fire && hit_lksel)
    begin
      lk_fifo <= wr_word[cfl_pkg::LK_FIFO_MSB:cfl_pkg::LK_FIFO_LSB];
      lk_buf  <= wr_word[cfl_pkg::LK_BUF_MSB:cfl_pkg::LK_BUF_LSB];
    end
  end

  // Restart the walk after any layout setting is written
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      kick <= 1'b0;
    else
      kick <= wr_fire && (hit_base || hit_fifo);
  end

  // Engine lookup, answered one cycle later
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_lk_addr  <= 32'h0;
      o_lk_valid <= 1'b0;
    end
    else
    begin
      o_lk_addr  <= cfl_pkg::addr_of(start_addr[i_lk.fifo], fcfg[i_lk.fifo], i_lk.bufi); // [RULE16]
      o_lk_valid <= i_lk.valid && !lay_stall;
    end
  end

  // Status outputs
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_base        <= cfl_pkg::BASE_RESET;
      o_op_code     <= cfl_pkg::OP_CONFIG;
      o_layout_busy <= 1'b1;
    end
    else
    begin
      o_base        <= base;
      o_op_code     <= cur_op;
      o_layout_busy <= lay_stall;
    end
  end

  // Settled layout: spacing between the selected FIFO and the next one
  sequence s_settled;
    !lay_stall && (lk_fifo != cfl_pkg::LAST_FIFO);
  endsequence

  property p_tx_gap;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      s_settled ##0 fcfg[lk_fifo].dir |->
        (start_addr[lk_fifo + 5'h1] - start_addr[lk_fifo]) ==
        ({27'h0, fcfg[lk_fifo].size} + 32'h1) * cfl_pkg::TX_BUF_BYTES;
  endproperty
  a_tx_gap: assert property (p_tx_gap) else $error("transmit FIFO footprint wrong"); // [RULE1]

  property p_rx_full_gap;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      s_settled ##0 (!fcfg[lk_fifo].dir && !fcfg[lk_fifo].payload_only_flag) |->
        (start_addr[lk_fifo + 5'h1] - start_addr[lk_fifo]) ==
        ({27'h0, fcfg[lk_fifo].size} + 32'h1) * cfl_pkg::RX_FULL_BYTES;
  endproperty
  a_rx_full_gap: assert property (p_rx_full_gap) else $error("full RX footprint wrong"); // [RULE2]

  property p_rx_data_gap;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      s_settled ##0 (!fcfg[lk_fifo].dir && fcfg[lk_fifo].payload_only_flag) |->
        (start_addr[lk_fifo + 5'h1] - start_addr[lk_fifo]) ==
        ({27'h0, fcfg[lk_fifo].size} + 32'h1) * cfl_pkg::RX_DATA_BYTES;
  endproperty
  a_rx_data_gap: assert property (p_rx_data_gap) else $error("data-only RX footprint wrong"); // [RULE3]

  // Default FIFO reserves one full-size buffer
  property p_unconf_gap;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      s_settled ##0 (fcfg[lk_fifo] == '0) |->
        (start_addr[lk_fifo + 5'h1] - start_addr[lk_fifo]) == cfl_pkg::RX_FULL_BYTES;
  endproperty
  a_unconf_gap: assert property (p_unconf_gap) else $error("unconfigured FIFO footprint wrong"); // [RULE6]

  // Every FIFO holds at least one buffer
  property p_min_one;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      s_settled |->
        (start_addr[lk_fifo + 5'h1] - start_addr[lk_fifo]) >= cfl_pkg::RX_DATA_BYTES;
  endproperty
  a_min_one: assert property (p_min_one) else $error("FIFO footprint too small"); // [RULE5]

  // FIFO zero starts at the base
  property p_origin;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      !lay_stall |-> (start_addr[0] == base);
  endproperty
  a_origin: assert property (p_origin) else $error("FIFO zero not at base"); // [RULE8]

  // Base write outside configuration leaves the base alone
  property p_base_lock;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      (wr_fire && hit_base && !in_config) |=> $stable(base);
  endproperty
  a_base_lock: assert property (p_base_lock) else $error("base changed outside config"); // [RULE15]

  // Size and payload flag writes outside configuration are dropped
  property p_fifo_lock;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      (wr_fire && hit_fifo && !in_config) |=>
        (fcfg[$past(fifo_sel)].size == $past(fcfg[fifo_sel].size)) &&
        (fcfg[$past(fifo_sel)].payload_only_flag == $past(fcfg[fifo_sel].payload_only_flag));
  endproperty
  a_fifo_lock: assert property (p_fifo_lock) else $error("size not locked"); // [RULE15]

  // Size and direction land from their bit fields
  property p_size_field;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      (wr_fire && hit_fifo && in_config && i_avs_byteenable[2]) |=>
        (fcfg[$past(fifo_sel)].size ==
         $past(i_avs_writedata[cfl_pkg::SIZE_MSB:cfl_pkg::SIZE_LSB]));
  endproperty
  a_size_field: assert property (p_size_field) else $error("size field not stored"); // [RULE4]

  property p_dir_bit;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      (wr_fire && hit_fifo && i_avs_byteenable[0]) |=>
        (fcfg[$past(fifo_sel)].dir == $past(i_avs_writedata[cfl_pkg::DIR_BIT]));
  endproperty
  a_dir_bit: assert property (p_dir_bit) else $error("direction bit not stored"); // [RULE9]

  // Engine answer uses the buffer stride of the FIFO
  property p_lk_stride;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      (i_lk.valid && !lay_stall && (i_lk.bufi == 5'h1) && $stable(start_addr)) |=>
        o_lk_valid && (o_lk_addr == start_addr[$past(i_lk.fifo)] +
                                    cfl_pkg::buf_bytes(fcfg[$past(i_lk.fifo)]));
  endproperty
  a_lk_stride: assert property (p_lk_stride) else $error("lookup stride wrong"); // [RULE16]

  // Payload-only receive buffers sit two words apart
  property p_lk_dstride;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      (i_lk.valid && !lay_stall && (i_lk.bufi == 5'h1) && !fcfg[i_lk.fifo].dir &&
       fcfg[i_lk.fifo].payload_only_flag && $stable(start_addr)) |=>
        (o_lk_addr == start_addr[$past(i_lk.fifo)] + cfl_pkg::RX_DATA_BYTES);
  endproperty
  a_lk_dstride: assert property (p_lk_dstride) else $error("data stride wrong"); // [RULE12]

endmodule
`default_nettype wire

// File: rtl/cfl_layout_walk.sv
// Layout walker: derives each FIFO start address by summing the lower FIFOs' footprints.
// Assumes settings stay stable while a walk runs; a new start pulse restarts the walk.
`timescale 1ns/1ps
`default_nettype none
module cfl_layout_walk (
  input  wire logic                  i_clk_sys,    // System clock
  input  wire logic                  i_arst_n,     // Async reset, active low
  input  wire logic                  i_start,      // Restart walk, one-cycle pulse
  input  wire logic [31:0]           i_base,       // Origin address
  input  wire cfl_pkg::cfl_fifo_cfg_t [cfl_pkg::NUM_FIFO-1:0] i_cfg, // FIFO settings
  output var  logic                  o_busy,       // Walk in progress
  output var  logic [cfl_pkg::NUM_FIFO-1:0][31:0] o_start_addr, // Start per FIFO
  output var  logic [31:0]           o_total       // Bytes of the whole layout
);

  logic [4:0]  idx;
  logic [31:0] acc;

  // One FIFO per cycle; reset launches a walk over the reset settings
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_busy       <= 1'b1;
      idx          <= 5'h0;
      acc          <= cfl_pkg::BASE_RESET;
      o_start_addr <= '0;
      o_total      <= 32'h0;
    end
    else if (i_start)
    begin
      o_busy <= 1'b1;
      idx    <= 5'h0;
      acc    <= i_base;                                  // [RULE8]
    end
    else if (o_busy)
    begin
      o_start_addr[idx] <= acc;                          // [RULE7] [RULE14]
      acc               <= acc + cfl_pkg::fifo_bytes(i_cfg[idx]); // [RULE6]
      idx               <= idx + 5'h1;
      if (idx == cfl_pkg::LAST_FIFO)
      begin
        o_busy  <= 1'b0;
        o_total <= acc + cfl_pkg::fifo_bytes(i_cfg[idx]) - i_base;
      end
    end
  end

  // Each step stores the running sum of the lower footprints
  property p_walk_step;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      (o_busy && !i_start) |=> (o_start_addr[$past(idx)] == $past(acc));
  endproperty
  a_walk_step: assert property (p_walk_step) else $error("walk stored wrong start"); // [RULE7]

  // A walk ends only after the last FIFO
  property p_walk_end;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      $fell(o_busy) |-> ($past(idx) == cfl_pkg::LAST_FIFO);
  endproperty
  a_walk_end: assert property (p_walk_end) else $error("walk ended early"); // [RULE7]

endmodule
`default_nettype wire

// File: rtl/cfl_op_mode.sv
// Operating mode tracker: the current code follows the requested one after a settle time.
// Assumes the request comes from a register on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cfl_op_mode (
  input  wire logic       i_clk_sys,   // System clock
  input  wire logic       i_arst_n,    // Async reset, active low
  input  wire logic [2:0] i_req_op,    // Requested op code
  output var  logic [2:0] o_cur_op,    // Current op code
  output var  logic       o_in_config  // Current code is configuration
);

  logic [3:0] cnt;

  // Settle counter and mode switch; reset lands in configuration
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_cur_op    <= cfl_pkg::OP_CONFIG;
      o_in_config <= 1'b1;
      cnt         <= 4'h0;
    end
    else if (o_cur_op == i_req_op)
      cnt <= 4'h0;
    else if (cnt == 4'(cfl_pkg::MODE_SETTLE_CYC - 1))
    begin
      o_cur_op    <= i_req_op;
      o_in_config <= (i_req_op == cfl_pkg::OP_CONFIG);
      cnt         <= 4'h0;
    end
    else
      cnt <= cnt + 4'h1;
  end

  // Mode never changes before the settle count is reached
  property p_mode_settle;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      (o_cur_op != $past(o_cur_op)) |-> ($past(cnt) == 4'(cfl_pkg::MODE_SETTLE_CYC - 1));
  endproperty
  a_mode_settle: assert property (p_mode_settle) else $error("mode changed early"); // [RULE10]

  // Config flag matches the current code
  property p_cfg_flag;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      o_in_config == (o_cur_op == cfl_pkg::OP_CONFIG);
  endproperty
  a_cfg_flag: assert property (p_cfg_flag) else $error("config flag mismatch"); // [RULE15]

endmodule
`default_nettype wire

// File: rtl/cfl_pkg.sv
// Constants, carriers and helper functions for the CAN message FIFO layout block.
// Assumes a 32-bit Avalon-MM register port with byte addresses and one 200 MHz clock.
package cfl_pkg;

  // Geometry
  localparam int unsigned NUM_FIFO = 32;
  localparam logic [4:0]  LAST_FIFO = 5'h1f;
  localparam int unsigned ADDR_W   = 9;

  // Register byte offsets
  localparam logic [8:0] OFS_CTRL      = 9'h000;
  localparam logic [8:0] OFS_BASE      = 9'h004;
  localparam logic [8:0] OFS_LKSEL     = 9'h008;
  localparam logic [8:0] OFS_LKADDR    = 9'h00c;
  localparam logic [8:0] OFS_TOTAL     = 9'h010;
  localparam logic [8:0] OFS_FIFO0     = 9'h100;
  localparam logic [8:0] OFS_FIFO_LAST = 9'h17c;

  // Control register fields
  localparam int unsigned BUSY_BIT = 0;
  localparam int unsigned CUR_LSB  = 21;
  localparam int unsigned CUR_MSB  = 23;
  localparam int unsigned REQ_LSB  = 24;
  localparam int unsigned REQ_MSB  = 26;

  // FIFO control register fields
  localparam int unsigned DIR_BIT   = 7;
  localparam int unsigned PAYLOAD_ONLY_FLAG_BIT = 12;
  localparam int unsigned SIZE_LSB  = 16;
  localparam int unsigned SIZE_MSB  = 20;

  // Lookup select fields
  localparam int unsigned LK_FIFO_LSB = 0;
  localparam int unsigned LK_FIFO_MSB = 4;
  localparam int unsigned LK_BUF_LSB  = 8;
  localparam int unsigned LK_BUF_MSB  = 12;

  // Operating mode codes
  localparam logic [2:0] OP_NORMAL = 3'h0;
  localparam logic [2:0] OP_CONFIG = 3'h4;

  // Buffer footprints in bytes, reset base address
  localparam logic [31:0] TX_BUF_BYTES   = 32'h10;
  localparam logic [31:0] RX_FULL_BYTES  = 32'h10;
  localparam logic [31:0] RX_DATA_BYTES  = 32'h8;
  localparam logic [31:0] BASE_RESET     = 32'h0;

  // Mode change settle time
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned MODE_SETTLE_NS  = 40;
  localparam int unsigned MODE_SETTLE_CYC =
    (MODE_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Per-FIFO layout settings
  typedef struct packed {
    logic       dir;    // 1 = transmit
    logic       payload_only_flag;  // payload-only receive
    logic [4:0] size;   // buffer count minus one
  } cfl_fifo_cfg_t;

  // Address lookup request from the protocol engine
  typedef struct packed {
    logic       valid;
    logic [4:0] fifo;
    logic [4:0] bufi;
  } cfl_lk_req_t;

  // Bytes taken by one buffer of a FIFO
  function automatic logic [31:0] buf_bytes(input cfl_fifo_cfg_t c);
    if (c.dir)
      return TX_BUF_BYTES;  // [RULE1] [RULE9]
    else if (c.payload_only_flag)
      return RX_DATA_BYTES; // [RULE3] [RULE12]
    else
      return RX_FULL_BYTES; // [RULE2]
  endfunction

  // Bytes taken by a whole FIFO, at least one buffer
  function automatic logic [31:0] fifo_bytes(input cfl_fifo_cfg_t c);
    logic [31:0] n;
    n = {27'h0, c.size} + 32'h1;  // [RULE5] [RULE11]
    return n * buf_bytes(c);
  endfunction

  // Address of buffer k inside a FIFO
  function automatic logic [31:0] addr_of(input logic [31:0] start,
                                          input cfl_fifo_cfg_t c,
                                          input logic [4:0] k);
    return start + {27'h0, k} * buf_bytes(c);
  endfunction

  // Merge write data into a word under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = new_w[i*8 +: 8];
    end
    return r;
  endfunction

endpackage
